//--- inc/slr_pkg.sv
/*
 * Constants, contact indices and states for the speed/load reference sequencer.
 * Assumes analog values arrive already converted: current in microamps, speeds and loads in whole units.
 */
package slr_pkg;
    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int REF_W = 16;
    localparam int FRAC_W = 8;
    localparam int ACC_W = REF_W + FRAC_W;
    localparam int MA_W = 16;
    localparam int CFG_W = 16;

    // ----------------------------------------------------------------
    // Remote input thresholds, microamps
    // ----------------------------------------------------------------
    localparam logic [MA_W-1:0] MA_FAULT_LO = 16'd2000;
    localparam logic [MA_W-1:0] MA_SPAN_LO = 16'd4000;
    localparam logic [MA_W-1:0] MA_SPAN_HI = 16'd20000;
    localparam logic [MA_W-1:0] MA_FAULT_HI = 16'd21000;

    // ----------------------------------------------------------------
    // Time units
    // ----------------------------------------------------------------
    localparam int MS_PER_S = 1000;
    localparam int S_PER_MIN = 60;
    localparam logic [ACC_W-1:0] NO_LOAD = 24'h000000;

    // ----------------------------------------------------------------
    // Synchronised contact indices
    // ----------------------------------------------------------------
    localparam int NSYNC = 9;
    localparam int C_PERMIT = 0;
    localparam int C_RESET = 1;
    localparam int C_IND = 2;
    localparam int C_RAISE = 3;
    localparam int C_LOWER = 4;
    localparam int C_RATED = 5;
    localparam int C_LOAD = 6;
    localparam int C_BASE = 7;
    localparam int C_BRK = 8;
    localparam logic [1:0] SYNC_LAST = 2'd2;
    localparam logic [1:0] SYNC_MID = 2'd1;

    typedef enum logic [2:0] {
        ST_START,
        ST_TO_IDLE,
        ST_IDLE,
        ST_ACCEL,
        ST_RATED,
        ST_DECEL
    } slr_state_t;
endpackage : slr_pkg

//--- src/slr_sequencer.sv
/*
 * Speed and load reference sequencer with alarm reset pulse generation and latched fault clearing.
 * Assumes EXEC_TICK is a one-cycle pulse from same-clock logic; contacts come from pins; config is static.
 */
// Overview of operation
// - Reset pulse clears only now-valid latched faults
// - Reset command true then false gives pulse
// - Run-permit close, or input D when optioned, pulses reset
// - Power-up and optional startup pulse reset
// - Local raise/lower ignored while remote enabled
// - Analog remote when raise+lower+rated, no fieldbus
// - Fieldbus remote when raise+lower+rated, fieldbus selected
// - Remote drives speed or baseload per option
// - Accel time up ramps, decel time down
// - Optional start reference first until speed exceeds
// - Idle selected while rated contact open
// - Rated close ramps idle to rated
// - Raise/lower cancels idle-to-rated ramp at once
// - At rated, raise/lower rates within limits
// - Linear remote map between end-point references
// - Below 2 mA or above 21 mA faulted
// - Ramp toward remote speed target at raise/lower rates
// - Remote fault holds or follows fault value
// - Remote selected during accel ramps at rates
// - Rated open ramps down to idle
// - Load rates, optional second pair via D
// - Load, unload to trip, breaker open, baseload
module slr_sequencer
#(
    parameter int TICK_HZ = 100,
    parameter int NFAULT = 8
)
(
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic CE,
    input wire logic EXEC_TICK,
    input wire logic RUN_PERMIT_CONTACT,
    input wire logic ALARM_RESET_CMD,
    input wire logic INPUT_D_CONTACT,
    input wire logic RAISE_CONTACT,
    input wire logic LOWER_CONTACT,
    input wire logic RATED_CONTACT,
    input wire logic LOAD_CONTACT,
    input wire logic BASELOAD_CONTACT,
    input wire logic BREAKER_CLOSED_CONTACT,
    input wire logic ENGINE_RUNNING,
    input wire logic ENGINE_CRANKING,
    input wire logic [slr_pkg::REF_W-1:0] ENGINE_SPEED,
    input wire logic START_REF_OPTION,
    input wire logic STARTUP_RESET_OPTION,
    input wire logic INPUT_D_RESET_OPTION,
    input wire logic SECOND_RATE_PAIR_OPTION,
    input wire logic REMOTE_TARGETS_SPEED_OPTION,
    input wire logic FIELDBUS_SELECT_OPTION,
    input wire logic LOCK_IN_LAST_OPTION,
    input wire logic [slr_pkg::REF_W-1:0] START_SETPOINT,
    input wire logic [slr_pkg::REF_W-1:0] IDLE_SETPOINT,
    input wire logic [slr_pkg::REF_W-1:0] RATED_SETPOINT,
    input wire logic [slr_pkg::REF_W-1:0] LOWER_LIMIT,
    input wire logic [slr_pkg::REF_W-1:0] RAISE_LIMIT,
    input wire logic [slr_pkg::CFG_W-1:0] ACCEL_TIME_MS,
    input wire logic [slr_pkg::CFG_W-1:0] DECEL_TIME_MS,
    input wire logic [slr_pkg::CFG_W-1:0] RAISE_RATE_PER_S,
    input wire logic [slr_pkg::CFG_W-1:0] LOWER_RATE_PER_S,
    input wire logic [slr_pkg::MA_W-1:0] REMOTE_INPUT_UA,
    input wire logic [slr_pkg::REF_W-1:0] REMOTE_LOW_END_REF,
    input wire logic [slr_pkg::REF_W-1:0] REMOTE_HIGH_END_REF,
    input wire logic [slr_pkg::REF_W-1:0] FIELDBUS_ANALOG_WRITE_VALUE,
    input wire logic [slr_pkg::REF_W-1:0] FIELDBUS_DEFAULT_VALUE,
    input wire logic FIELDBUS_LINK_ERROR,
    input wire logic [slr_pkg::REF_W-1:0] LOADSHARE_SETPOINT,
    input wire logic [slr_pkg::REF_W-1:0] BASELOAD_SETPOINT,
    input wire logic [slr_pkg::REF_W-1:0] UNLOAD_TRIP_LEVEL,
    input wire logic [slr_pkg::REF_W-1:0] RATED_LOAD,
    input wire logic [slr_pkg::CFG_W-1:0] LOAD_RATE_PER_MIN,
    input wire logic [slr_pkg::CFG_W-1:0] UNLOAD_RATE_PER_MIN,
    input wire logic [slr_pkg::CFG_W-1:0] LOAD_RATE2_PER_MIN,
    input wire logic [slr_pkg::CFG_W-1:0] UNLOAD_RATE2_PER_MIN,
    input wire logic [NFAULT-1:0] FAULT_SET,
    input wire logic [NFAULT-1:0] PARAM_VALID,
    output logic [NFAULT-1:0] FAULT_LATCHED,
    output logic ALARM_RESET,
    output logic [slr_pkg::REF_W-1:0] SPEED_REF,
    output logic [slr_pkg::REF_W-1:0] LOAD_REF,
    output logic BREAKER_OPEN_CMD,
    output logic REMOTE_FAULT,
    output logic REMOTE_ACTIVE
);
    import slr_pkg::*;

    // ----------------------------------------------------------------
    // Contact synchronisers
    // ----------------------------------------------------------------
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] db_reg;
    logic [NSYNC-1:0] db_prev_reg;
    logic [2:0] sync_reg [NSYNC];

    assign pin_raw = {BREAKER_CLOSED_CONTACT, BASELOAD_CONTACT, LOAD_CONTACT, RATED_CONTACT, LOWER_CONTACT,
                      RAISE_CONTACT, INPUT_D_CONTACT, ALARM_RESET_CMD, RUN_PERMIT_CONTACT};

    generate
        for (genvar i = 0; i < NSYNC; i++) begin : g_sync
            always_ff @(posedge SYS_CLK) begin
                if (!NRST) begin
                    sync_reg[i] <= 3'h0;
                    db_reg[i] <= 1'b0;
                    db_prev_reg[i] <= 1'b0;
                end else if (CE) begin
                    sync_reg[i] <= {sync_reg[i][SYNC_MID], sync_reg[i][0], pin_raw[i]};
                    if (sync_reg[i][SYNC_MID] == sync_reg[i][SYNC_LAST]) begin
                        db_reg[i] <= sync_reg[i][SYNC_LAST];
                    end
                    db_prev_reg[i] <= db_reg[i];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Alarm reset
    // ----------------------------------------------------------------
    logic cmd_arm_reg;
    logic por_pend_reg;
    logic crank_prev_reg;
    logic reset_event;

    assign reset_event = (cmd_arm_reg && !db_reg[C_RESET])
        || (db_reg[C_PERMIT] && !db_prev_reg[C_PERMIT])
        || (INPUT_D_RESET_OPTION && db_reg[C_IND] && !db_prev_reg[C_IND])
        || por_pend_reg
        || (STARTUP_RESET_OPTION && ENGINE_CRANKING && !crank_prev_reg);

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            cmd_arm_reg <= 1'b0;
            por_pend_reg <= 1'b1;
            crank_prev_reg <= 1'b0;
            ALARM_RESET <= 1'b0;
        end else if (CE) begin
            cmd_arm_reg <= db_reg[C_RESET];
            por_pend_reg <= 1'b0;
            crank_prev_reg <= ENGINE_CRANKING;
            ALARM_RESET <= reset_event;
        end
    end

    generate
        for (genvar i = 0; i < NFAULT; i++) begin : g_fault
            always_ff @(posedge SYS_CLK) begin
                if (!NRST) begin
                    FAULT_LATCHED[i] <= 1'b0;
                end else if (CE) begin
                    FAULT_LATCHED[i] <= FAULT_SET[i] || (FAULT_LATCHED[i] && !(ALARM_RESET && PARAM_VALID[i]));
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Remote reference selection and scaling
    // ----------------------------------------------------------------
    logic remote_en;
    logic analog_sel;
    logic bus_sel;
    logic ma_fault;
    logic remote_hold;
    logic signed [31:0] ma_off;
    logic signed [31:0] map_val;
    logic [REF_W-1:0] remote_val;

    assign remote_en = db_reg[C_RAISE] && db_reg[C_LOWER] && db_reg[C_RATED];
    assign analog_sel = remote_en && !FIELDBUS_SELECT_OPTION;
    assign bus_sel = remote_en && FIELDBUS_SELECT_OPTION;
    assign ma_fault = (REMOTE_INPUT_UA < MA_FAULT_LO) || (REMOTE_INPUT_UA > MA_FAULT_HI);
    assign ma_off = $signed({16'h0000, REMOTE_INPUT_UA}) - $signed({16'h0000, MA_SPAN_LO});
    assign map_val = $signed({16'h0000, REMOTE_LOW_END_REF})
        + (ma_off * ($signed({16'h0000, REMOTE_HIGH_END_REF}) - $signed({16'h0000, REMOTE_LOW_END_REF})))
        / $signed({16'h0000, MA_SPAN_HI - MA_SPAN_LO});
    assign remote_hold = LOCK_IN_LAST_OPTION && ((analog_sel && ma_fault) || (bus_sel && FIELDBUS_LINK_ERROR));

    always_comb begin
        if (bus_sel) begin
            remote_val = FIELDBUS_LINK_ERROR ? FIELDBUS_DEFAULT_VALUE : FIELDBUS_ANALOG_WRITE_VALUE;
        end else if (map_val < 0) begin
            remote_val = '0;
        end else if (map_val > 32'sh0000ffff) begin
            remote_val = '1;
        end else begin
            remote_val = map_val[REF_W-1:0];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            REMOTE_FAULT <= 1'b0;
            REMOTE_ACTIVE <= 1'b0;
        end else if (CE) begin
            REMOTE_FAULT <= (analog_sel && ma_fault) || (bus_sel && FIELDBUS_LINK_ERROR);
            REMOTE_ACTIVE <= remote_en;
        end
    end

    // ----------------------------------------------------------------
    // Per-tick increments
    // ----------------------------------------------------------------
    function automatic logic [ACC_W-1:0] fx(input logic [REF_W-1:0] v);
        fx = {v, {FRAC_W{1'b0}}};
    endfunction : fx

    function automatic logic [ACC_W-1:0] per_tick(input logic [31:0] amount, input logic [31:0] ticks);
        logic [31:0] q;
        q = (amount << FRAC_W) / ((ticks == 32'h0) ? 32'h1 : ticks);
        per_tick = q[ACC_W-1:0];
    endfunction : per_tick

    function automatic logic [ACC_W-1:0] step(input logic [ACC_W-1:0] cur, input logic [ACC_W-1:0] tgt,
                                             input logic [ACC_W-1:0] up, input logic [ACC_W-1:0] dn);
        if (cur < tgt) begin
            step = (tgt - cur > up) ? cur + up : tgt;
        end else begin
            step = (cur - tgt > dn) ? cur - dn : tgt;
        end
    endfunction : step

    function automatic logic [ACC_W-1:0] clamp(input logic [ACC_W-1:0] v, input logic [REF_W-1:0] lo,
                                              input logic [REF_W-1:0] hi);
        clamp = (v < fx(lo)) ? fx(lo) : ((v > fx(hi)) ? fx(hi) : v);
    endfunction : clamp

    logic [31:0] accel_ticks;
    logic [31:0] decel_ticks;
    logic [REF_W-1:0] up_span;
    logic [REF_W-1:0] start_span;
    logic [ACC_W-1:0] acc_inc;
    logic [ACC_W-1:0] start_inc;
    logic [ACC_W-1:0] dec_inc;
    logic [ACC_W-1:0] raise_inc;
    logic [ACC_W-1:0] lower_inc;
    logic [ACC_W-1:0] load_inc;
    logic [ACC_W-1:0] unload_inc;
    logic second_pair;

    assign accel_ticks = (32'(ACCEL_TIME_MS) * 32'(TICK_HZ)) / 32'(MS_PER_S);
    assign decel_ticks = (32'(DECEL_TIME_MS) * 32'(TICK_HZ)) / 32'(MS_PER_S);
    assign up_span = (RATED_SETPOINT > IDLE_SETPOINT) ? RATED_SETPOINT - IDLE_SETPOINT : '0;
    assign start_span = (IDLE_SETPOINT > START_SETPOINT) ? IDLE_SETPOINT - START_SETPOINT
                                                          : START_SETPOINT - IDLE_SETPOINT;
    assign acc_inc = per_tick(32'(up_span), accel_ticks);
    assign start_inc = per_tick(32'(start_span), accel_ticks);
    assign dec_inc = per_tick(32'(up_span), decel_ticks);
    assign raise_inc = per_tick(32'(RAISE_RATE_PER_S), 32'(TICK_HZ));
    assign lower_inc = per_tick(32'(LOWER_RATE_PER_S), 32'(TICK_HZ));
    assign second_pair = SECOND_RATE_PAIR_OPTION && db_reg[C_IND];
    assign load_inc = per_tick(32'(second_pair ? LOAD_RATE2_PER_MIN : LOAD_RATE_PER_MIN), 32'(TICK_HZ * S_PER_MIN));
    assign unload_inc = per_tick(32'(second_pair ? UNLOAD_RATE2_PER_MIN : UNLOAD_RATE_PER_MIN),
                                 32'(TICK_HZ * S_PER_MIN));

    // ----------------------------------------------------------------
    // Speed reference sequencing
    // ----------------------------------------------------------------
    slr_state_t state_reg;
    slr_state_t state_next;
    logic [ACC_W-1:0] speed_reg;
    logic [ACC_W-1:0] speed_next;
    logic start_force;
    logic local_raise;
    logic local_lower;
    logic remote_speed;

    assign start_force = START_REF_OPTION && (!ENGINE_RUNNING || ENGINE_CRANKING)
        && (ENGINE_SPEED <= START_SETPOINT);
    assign local_raise = db_reg[C_RAISE] && !remote_en;
    assign local_lower = db_reg[C_LOWER] && !remote_en;
    assign remote_speed = remote_en && REMOTE_TARGETS_SPEED_OPTION;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_START: if (!start_force) state_next = ST_TO_IDLE;
            ST_TO_IDLE: if (speed_reg == fx(IDLE_SETPOINT)) state_next = ST_IDLE;
            ST_IDLE: if (db_reg[C_RATED]) state_next = ST_ACCEL;
            ST_ACCEL: begin
                if (!db_reg[C_RATED]) begin
                    state_next = ST_DECEL;
                end else if (db_reg[C_RAISE] || db_reg[C_LOWER] || speed_reg == fx(RATED_SETPOINT)) begin
                    state_next = ST_RATED;
                end
            end
            ST_RATED: if (!db_reg[C_RATED]) state_next = ST_DECEL;
            ST_DECEL: begin
                if (db_reg[C_RATED]) begin
                    state_next = ST_ACCEL;
                end else if (speed_reg == fx(IDLE_SETPOINT)) begin
                    state_next = ST_IDLE;
                end
            end
        endcase
        if (start_force) begin
            state_next = ST_START;
        end
    end

    always_comb begin
        speed_next = speed_reg;
        unique case (state_reg)
            ST_START: speed_next = fx(START_SETPOINT);
            ST_TO_IDLE: speed_next = step(speed_reg, fx(IDLE_SETPOINT), start_inc, start_inc);
            ST_IDLE: speed_next = step(speed_reg, fx(IDLE_SETPOINT), acc_inc, dec_inc);
            ST_ACCEL: speed_next = step(speed_reg, fx(RATED_SETPOINT), acc_inc, acc_inc);
            ST_DECEL: speed_next = step(speed_reg, fx(IDLE_SETPOINT), dec_inc, dec_inc);
            ST_RATED: begin
                if (remote_speed && !remote_hold) begin
                    speed_next = step(speed_reg, clamp(fx(remote_val), LOWER_LIMIT, RAISE_LIMIT),
                                      raise_inc, lower_inc);
                end else if (local_raise && !local_lower) begin
                    speed_next = step(speed_reg, fx(RAISE_LIMIT), raise_inc, lower_inc);
                end else if (local_lower && !local_raise) begin
                    speed_next = step(speed_reg, fx(LOWER_LIMIT), raise_inc, lower_inc);
                end
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            state_reg <= ST_START;
            speed_reg <= '0;
        end else if (CE && EXEC_TICK) begin
            state_reg <= state_next;
            speed_reg <= speed_next;
        end
    end

    assign SPEED_REF = speed_reg[ACC_W-1:FRAC_W];

    // ----------------------------------------------------------------
    // Load reference
    // ----------------------------------------------------------------
    logic [ACC_W-1:0] load_reg;
    logic [ACC_W-1:0] load_tgt;
    logic load_hold;

    always_comb begin
        load_hold = 1'b0;
        if (!db_reg[C_BRK]) begin
            load_tgt = NO_LOAD;
        end else if (db_reg[C_BASE]) begin
            load_hold = remote_en && !REMOTE_TARGETS_SPEED_OPTION && remote_hold;
            load_tgt = (remote_en && !REMOTE_TARGETS_SPEED_OPTION)
                ? clamp(fx(remote_val), UNLOAD_TRIP_LEVEL, RATED_LOAD) : fx(BASELOAD_SETPOINT);
        end else if (db_reg[C_LOAD]) begin
            load_tgt = fx(LOADSHARE_SETPOINT);
        end else begin
            load_tgt = fx(UNLOAD_TRIP_LEVEL);
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            load_reg <= NO_LOAD;
            BREAKER_OPEN_CMD <= 1'b0;
        end else if (CE && EXEC_TICK) begin
            if (!db_reg[C_BRK]) begin
                load_reg <= NO_LOAD;
            end else if (!load_hold) begin
                load_reg <= step(load_reg, load_tgt, load_inc, unload_inc);
            end
            BREAKER_OPEN_CMD <= db_reg[C_BRK] && !db_reg[C_LOAD] && !db_reg[C_BASE]
                && (load_reg <= fx(UNLOAD_TRIP_LEVEL));
        end
    end

    assign LOAD_REF = load_reg[ACC_W-1:FRAC_W];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_release;
        CE && cmd_arm_reg && !db_reg[C_RESET];
    endsequence
    sequence s_permit_close;
        CE && db_reg[C_PERMIT] && !db_prev_reg[C_PERMIT];
    endsequence

    reset_single_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        (ALARM_RESET && CE && !reset_event) ##1 CE |-> !ALARM_RESET) else $error("reset pulse too long");
    cmd_release_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        s_release |=> ALARM_RESET) else $error("no pulse on command release");
    permit_close_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        s_permit_close |=> ALARM_RESET) else $error("no pulse on run permit");
    fault_clear_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        (CE && ALARM_RESET && PARAM_VALID[0] && !FAULT_SET[0]) |=> !FAULT_LATCHED[0]) else $error("fault kept");
    fault_keep_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        (CE && FAULT_LATCHED[0] && !PARAM_VALID[0]) |=> FAULT_LATCHED[0]) else $error("invalid fault cleared");
    ramp_cancel_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        (CE && EXEC_TICK && state_reg == ST_ACCEL && db_reg[C_RATED] && !start_force && db_reg[C_RAISE])
        |=> state_reg == ST_RATED) else $error("accel ramp not cancelled");
    idle_return_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        (CE && EXEC_TICK && state_reg == ST_RATED && !db_reg[C_RATED] && !start_force)
        |=> state_reg == ST_DECEL) else $error("no decel on idle select");
    local_ignore_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        (CE && EXEC_TICK && state_reg == ST_RATED && remote_en && !REMOTE_TARGETS_SPEED_OPTION && !start_force)
        |=> $stable(speed_reg)) else $error("speed moved by ignored contacts");
endmodule : slr_sequencer

//--- verif/slr_contacts.sv
/* Operator contacts and fieldbus master model for the reference sequencer.
   Assumes the bench calls its tasks from one process, just after clock edges. */
module slr_contacts
(
    input wire logic clk,
    output logic [8:0] pins,
    output logic [15:0] aw_value,
    output logic link_err
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        pins = 9'h000;
        aw_value = 16'h00b4;
        link_err = 1'b0;
    end
    // ----------------------------------------
    // Contact moves; one pin set to the given level 1 ns after the next clock edge
    // ----------------------------------------
    task automatic set_pin(input int i, input logic v);
        @(posedge clk);
        #1 pins[i] = v;
    endtask : set_pin
    // Master writes the analog write value
    task automatic write_aw(input logic [15:0] v, input logic e);
        @(posedge clk);
        #1 aw_value = v;
        link_err = e;
    endtask : write_aw
endmodule : slr_contacts

//--- verif/slr_sequencer_bench.sv
/* Self-checking bench for the reference sequencer.
   Assumes a tick every 4 clocks, TICK_HZ 100, contacts from slr_contacts. */
module slr_sequencer_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import slr_pkg::*;
    logic clk = 0, nrst = 0, tick = 0, eng_run = 1, crank = 0, err;
    logic [1:0] tc = 2'h0;
    logic [8:0] pins;
    logic [6:0] opt = 7'h00;
    logic [15:0] cfg [0:19];
    logic [15:0] aw, v, ua = 16'h2ee0, sref, lref, npulse = 16'h0000, nmid = 16'h0000, m0;
    logic [7:0] fset = 8'h00, pv = 8'h00, flat, fs;
    logic ar, bopen, rfault, ract;
    int mismatches = 0, checks = 0;
    initial cfg = '{16'h0000, 16'h0064, 16'h00c8, 16'h0096, 16'h00dc, 16'h0064, 16'h00c8, 16'h0064,
        16'h0064, 16'h00a0, 16'h00c8, 16'h0000, 16'h0032, 16'h0050, 16'h000a, 16'h0064,
        16'h1770, 16'h1770, 16'h1770, 16'h1770};
    initial forever #2 clk = ~clk;
    always @(posedge clk) begin
        tc <= tc + 2'h1;
        tick <= (tc == 2'h3);
        if (ar === 1'b1) npulse <= npulse + 16'h1;
        if (tick && sref > cfg[1] && sref < cfg[3]) nmid <= nmid + 16'h1;
    end
    slr_contacts pc (.clk(clk), .pins(pins), .aw_value(aw), .link_err(err));
    slr_sequencer uut (.SYS_CLK(clk), .NRST(nrst), .CE(1'b1), .EXEC_TICK(tick),
        .RUN_PERMIT_CONTACT(pins[C_PERMIT]), .ALARM_RESET_CMD(pins[C_RESET]), .INPUT_D_CONTACT(pins[C_IND]),
        .RAISE_CONTACT(pins[C_RAISE]), .LOWER_CONTACT(pins[C_LOWER]), .RATED_CONTACT(pins[C_RATED]),
        .LOAD_CONTACT(pins[C_LOAD]), .BASELOAD_CONTACT(pins[C_BASE]), .BREAKER_CLOSED_CONTACT(pins[C_BRK]),
        .ENGINE_RUNNING(eng_run), .ENGINE_CRANKING(crank), .ENGINE_SPEED(16'h0000),
        .START_REF_OPTION(opt[0]), .STARTUP_RESET_OPTION(opt[1]), .INPUT_D_RESET_OPTION(opt[2]),
        .SECOND_RATE_PAIR_OPTION(opt[3]), .REMOTE_TARGETS_SPEED_OPTION(opt[4]),
        .FIELDBUS_SELECT_OPTION(opt[5]), .LOCK_IN_LAST_OPTION(opt[6]),
        .START_SETPOINT(cfg[0]), .IDLE_SETPOINT(cfg[1]), .RATED_SETPOINT(cfg[2]), .LOWER_LIMIT(cfg[3]),
        .RAISE_LIMIT(cfg[4]), .ACCEL_TIME_MS(cfg[5]), .DECEL_TIME_MS(cfg[6]), .RAISE_RATE_PER_S(cfg[7]),
        .LOWER_RATE_PER_S(cfg[8]), .REMOTE_INPUT_UA(ua), .REMOTE_LOW_END_REF(cfg[9]),
        .REMOTE_HIGH_END_REF(cfg[10]), .FIELDBUS_ANALOG_WRITE_VALUE(aw), .FIELDBUS_DEFAULT_VALUE(cfg[11]),
        .FIELDBUS_LINK_ERROR(err), .LOADSHARE_SETPOINT(cfg[12]), .BASELOAD_SETPOINT(cfg[13]),
        .UNLOAD_TRIP_LEVEL(cfg[14]), .RATED_LOAD(cfg[15]), .LOAD_RATE_PER_MIN(cfg[16]),
        .UNLOAD_RATE_PER_MIN(cfg[17]), .LOAD_RATE2_PER_MIN(cfg[18]), .UNLOAD_RATE2_PER_MIN(cfg[19]),
        .FAULT_SET(fset), .PARAM_VALID(pv), .FAULT_LATCHED(flat), .ALARM_RESET(ar), .SPEED_REF(sref),
        .LOAD_REF(lref), .BREAKER_OPEN_CMD(bopen), .REMOTE_FAULT(rfault), .REMOTE_ACTIVE(ract));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic ticks(input int n);
        repeat (n * 4) @(posedge clk);
        #1;
    endtask : ticks
    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    initial begin
        #100000;
        mismatches++;
        wrap_up();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        void'($urandom(32'h18996938));
        repeat (6) @(posedge clk);
        #1 nrst = 1;
        ticks(2);
        check(npulse, 16'h1);
        fs = 8'($urandom);
        fset = fs;
        pv = 8'($urandom);
        ticks(1);
        fset = 8'h00;
        pc.set_pin(C_RESET, 1);
        ticks(3);
        check(npulse, 16'h1);
        pc.set_pin(C_RESET, 0);
        ticks(3);
        check(npulse, 16'h2);
        check({8'h00, flat}, {8'h00, fs & ~pv});
        pc.set_pin(C_PERMIT, 1);
        pc.set_pin(C_IND, 1);
        ticks(3);
        check(npulse, 16'h3);
        pc.set_pin(C_IND, 0);
        ticks(2);
        opt[2] = 1'b1;
        pc.set_pin(C_IND, 1);
        ticks(3);
        check(npulse, 16'h4);
        pc.set_pin(C_IND, 0);
        opt[1] = 1'b1;
        crank = 1'b1;
        ticks(3);
        check(npulse, 16'h5);
        crank = 1'b0;
        $display("test alarm reset done");
        ticks(40);
        check(sref, 16'h0064);
        m0 = nmid;
        pc.set_pin(C_RATED, 1);
        ticks(30);
        check(sref, 16'h00c8);
        check(nmid - m0, 16'h4);
        pc.set_pin(C_RAISE, 1);
        ticks(40);
        check(sref, 16'h00dc);
        pc.set_pin(C_RAISE, 0);
        pc.set_pin(C_LOWER, 1);
        ticks(90);
        check(sref, 16'h0096);
        $display("test local speed done");
        opt[5:4] = 2'h3;
        v = 16'(160 + $urandom_range(50));
        pc.write_aw(v, 0);
        pc.set_pin(C_RAISE, 1);
        ticks(80);
        check({15'h0, ract}, 16'h1);
        check(sref, v);
        opt[6] = 1'b1;
        pc.write_aw(16'h00dc, 1);
        ticks(20);
        check(sref, v);
        opt[4] = 1'b0;
        ticks(10);
        check(sref, v);
        opt[6:4] = 3'h1;
        ticks(80);
        check(sref, 16'h00b4);
        ua = 16'h03e8;
        ticks(3);
        check({15'h0, rfault}, 16'h1);
        ticks(40);
        check(sref, 16'h0099);
        pc.set_pin(C_RAISE, 0);
        pc.set_pin(C_LOWER, 0);
        m0 = nmid;
        pc.set_pin(C_RATED, 0);
        ticks(40);
        check(sref, 16'h0064);
        check(nmid - m0, 16'ha);
        $display("test remote and decel done");
        pc.set_pin(C_BRK, 1);
        pc.set_pin(C_LOAD, 1);
        ticks(70);
        check(lref, 16'h0032);
        pc.set_pin(C_LOAD, 0);
        ticks(60);
        check(lref, 16'h000a);
        check({15'h0, bopen}, 16'h1);
        $display("test load done");
        wrap_up();
    end
endmodule : slr_sequencer_bench
